/* cpu_regs_defs.svh */
`ifndef CPU_REGS_DEFS_SVH
`define CPU_REGS_DEFS_SVH

// ----------------------------------------
// system register numbers
// ----------------------------------------
`define SR_MASK_PC 5'h00
`define SR_MASK_PSW 5'h01
`define SR_NMI_PC 5'h02
`define SR_NMI_PSW 5'h03
`define SR_EXC_CODE 5'h04
`define SR_PSW 5'h05
`define SR_TBL_PC 5'h10
`define SR_TBL_PSW 5'h11
`define SR_DBG_PC 5'h12
`define SR_DBG_PSW 5'h13
`define SR_TBL_BASE 5'h14

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define PC_MASK 32'h03FFFFFE
`define PSW_MASK 32'h000000FF
`define PSW_NMI_BIT 7
`define PSW_EXC_BIT 6
`define PSW_IDIS_BIT 5
`define PSW_RESET 32'h00000020
`define PC_RESET 32'h00000000
`define ZERO_WORD 32'h00000000

`endif

/* cpu_regs_pkg.sv */
package cpu_regs_pkg;

  // ----------------------------------------
  // event carriers
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] data;
    logic en;
  } gpr_wr_t;

  typedef struct packed {
    logic [4:0] num;
    logic [31:0] data;
    logic ld;
  } sr_wr_t;

  typedef enum logic [2:0] {
    EV_NONE,
    EV_MASKABLE,
    EV_NMI,
    EV_TABLE_CALL,
    EV_DEBUG_TRAP,
    EV_INT_RETURN,
    EV_DEBUG_RETURN
  } cpu_event_t;

  typedef enum {
    DBG_IDLE,
    DBG_OPEN
  } dbg_state_t;

endpackage : cpu_regs_pkg

/* gpr_file.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defs.svh"

module gpr_file #(
  parameter int NREGS = 32,
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // write port
  input wire cpu_regs_pkg::gpr_wr_t wr,
  // read ports
  input wire logic [4:0] rd_a_addr,
  input wire logic [4:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_a_data,
  output logic [WIDTH-1:0] rd_b_data
);
  import cpu_regs_pkg::*;

  logic [WIDTH-1:0] mem_ff [NREGS];

  // entry zero never stores, so it stays at its reset zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NREGS; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr.en && wr.addr != 5'h00) begin // see RQ23
      mem_ff[wr.addr] <= wr.data;
    end
  end

  // write-through forwarding, still zero for entry zero
  function automatic logic [WIDTH-1:0] rd_fwd(input logic [4:0] a,
                                              input gpr_wr_t w,
                                              input logic [WIDTH-1:0] stored);
    if (a == 5'h00) begin
      rd_fwd = '0; // see RQ3
    end else if (w.en && w.addr == a) begin
      rd_fwd = w.data; // see RQ23
    end else begin
      rd_fwd = stored;
    end
  endfunction : rd_fwd

  always_comb begin
    rd_a_data = rd_fwd(rd_a_addr, wr, mem_ff[rd_a_addr]); // see RQ1
    rd_b_data = rd_fwd(rd_b_addr, wr, mem_ff[rd_b_addr]);
  end

endmodule : gpr_file

`default_nettype wire

/* cpu_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defs.svh"

// How it works
// RQ1: thirty-two 32-bit general registers
// RQ2: all registers 32 bits, reserved bits zero
// RQ3: register zero always reads zero
// RQ4: program counter keeps low 26 bits
// RQ5: program counter bit 0 fixed zero
// RQ6: system registers selected by register number
// RQ7: reserved numbers: loads ignored, reads zero
// RQ8: exception code not writable by load
// RQ9: debug saves only inside debug window
// RQ10: return forces pc bit 0 zero
// RQ11: maskable event saves pc and status
// RQ12: saved pc is next-instruction address
// RQ13: single maskable save pair, overwritten
// RQ14: nmi saves into nmi save pair
// RQ15: save registers mask reserved bits
// RQ16: return restores from maskable saves
// RQ17: return restores from nmi saves
// RQ18: any event records its exception code; here only maskable, nmi and debug trap events record one
// RQ19: status word flag layout, bits 7..0
// RQ20: status load visible next, holds acks
// RQ21: table call saves next pc, status
// RQ22: return source chosen by nmi flag
// RQ23: writes to register zero discarded

module cpu_regs #(
  parameter int PC_WIDTH = 26
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // general register ports
  input wire cpu_regs_pkg::gpr_wr_t gpr_wr,
  input wire logic [4:0] gpr_rd_a_addr,
  input wire logic [4:0] gpr_rd_b_addr,
  output logic [31:0] gpr_rd_a_data,
  output logic [31:0] gpr_rd_b_data,
  // program counter update
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire logic [31:0] next_instr_addr,
  // events from execution and interrupt acknowledge
  input wire cpu_regs_pkg::cpu_event_t event_kind,
  input wire logic [31:0] event_code,
  input wire logic [31:0] event_new_pc,
  input wire logic [7:0] event_new_psw,
  input wire logic [7:0] flags_upd,
  input wire logic flags_upd_en,
  // system register load and store
  input wire cpu_regs_pkg::sr_wr_t sr_wr,
  input wire logic [4:0] sr_rd_num,
  output logic [31:0] sr_rd_data,
  // status outputs
  output logic [31:0] pc,
  output logic [31:0] processor_status_word,
  output logic ack_hold,
  output logic debug_window
);
  import cpu_regs_pkg::*;

  // ----------------------------------------
  // general registers
  // ----------------------------------------
  logic [31:0] ga_w;
  logic [31:0] gb_w;
  logic [31:0] ga_ff;
  logic [31:0] gb_ff;

  gpr_file #(.NREGS(32), .WIDTH(32)) u_gpr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr(gpr_wr),
    .rd_a_addr(gpr_rd_a_addr),
    .rd_b_addr(gpr_rd_b_addr),
    .rd_a_data(ga_w),
    .rd_b_data(gb_w)
  );

  // registered read, one cycle latency
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ga_ff <= `ZERO_WORD;
      gb_ff <= `ZERO_WORD;
    end else begin
      ga_ff <= ga_w;
      gb_ff <= gb_w;
    end
  end
  assign gpr_rd_a_data = ga_ff;
  assign gpr_rd_b_data = gb_ff;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // low PC_WIDTH bits kept, upper bits dropped as a carry out would be
  localparam logic [31:0] PCK = (32'h00000001 << PC_WIDTH) - 32'h00000001;
  localparam logic [31:0] PCM = `PC_MASK & PCK;

  function automatic logic [31:0] pc_fix(input logic [31:0] v);
    pc_fix = v & PCM; // see RQ4 // see RQ5 // see RQ10
  endfunction : pc_fix

  function automatic logic [31:0] psw_fix(input logic [31:0] v);
    psw_fix = v & `PSW_MASK; // see RQ15 // see RQ19
  endfunction : psw_fix

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] pc_ff;
  logic [31:0] psw_ff;
  logic [31:0] mpc_ff;
  logic [31:0] mpsw_ff;
  logic [31:0] npc_ff;
  logic [31:0] npsw_ff;
  logic [31:0] ecode_ff;
  logic [31:0] tpc_ff;
  logic [31:0] tpsw_ff;
  logic [31:0] dpc_ff;
  logic [31:0] dpsw_ff;
  logic [31:0] tbase_ff;
  logic [31:0] rd_ff;
  logic hold_ff;
  dbg_state_t dbg_ff;
  dbg_state_t nxt_dbg;

  logic ld_ok;
  logic dbg_ok;
  assign dbg_ok = (dbg_ff == DBG_OPEN);
  assign ld_ok = sr_wr.ld;

  // ----------------------------------------
  // debug access window
  // ----------------------------------------
  always_comb begin
    nxt_dbg = dbg_ff;
    case (dbg_ff)
      DBG_IDLE: begin
        if (event_kind == EV_DEBUG_TRAP) nxt_dbg = DBG_OPEN; // see RQ9
      end
      DBG_OPEN: begin
        if (event_kind == EV_DEBUG_RETURN) nxt_dbg = DBG_IDLE; // see RQ9
      end
      default: nxt_dbg = DBG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) dbg_ff <= DBG_IDLE;
    else dbg_ff <= nxt_dbg;
  end

  // ----------------------------------------
  // program counter and status word
  // ----------------------------------------
  // events outrank a status load in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_ff <= `PC_RESET;
      psw_ff <= `PSW_RESET;
    end else begin
      case (event_kind)
        EV_MASKABLE, EV_NMI, EV_TABLE_CALL, EV_DEBUG_TRAP: begin
          pc_ff <= pc_fix(event_new_pc);
          psw_ff <= psw_fix({24'h000000, event_new_psw});
        end
        EV_INT_RETURN: begin
          if (psw_ff[`PSW_NMI_BIT]) begin // see RQ22
            pc_ff <= pc_fix(npc_ff); // see RQ17
            psw_ff <= npsw_ff;
          end else begin
            pc_ff <= pc_fix(mpc_ff); // see RQ16
            psw_ff <= mpsw_ff;
          end
        end
        EV_DEBUG_RETURN: begin
          pc_ff <= pc_fix(dpc_ff);
          psw_ff <= dpsw_ff;
        end
        default: begin
          if (pc_load) pc_ff <= pc_fix(pc_next);
          if (ld_ok && sr_wr.num == `SR_PSW) begin
            psw_ff <= psw_fix(sr_wr.data); // see RQ20
          end else if (flags_upd_en) begin
            psw_ff <= psw_fix({24'h000000, flags_upd});
          end
        end
      endcase
    end
  end

  // hold acknowledgment for the cycle a status load lands
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) hold_ff <= 1'b0;
    else hold_ff <= ld_ok && sr_wr.num == `SR_PSW; // see RQ20
  end

  // ----------------------------------------
  // save registers
  // ----------------------------------------
  // only one maskable pair: nesting overwrites it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mpc_ff <= `ZERO_WORD;
      mpsw_ff <= `ZERO_WORD;
    end else if (event_kind == EV_MASKABLE) begin // see RQ11 // see RQ13
      mpc_ff <= pc_fix(next_instr_addr); // see RQ12
      mpsw_ff <= psw_ff;
    end else if (ld_ok && sr_wr.num == `SR_MASK_PC) begin // see RQ6
      mpc_ff <= sr_wr.data & PCK; // see RQ15
    end else if (ld_ok && sr_wr.num == `SR_MASK_PSW) begin
      mpsw_ff <= psw_fix(sr_wr.data);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      npc_ff <= `ZERO_WORD;
      npsw_ff <= `ZERO_WORD;
    end else if (event_kind == EV_NMI) begin // see RQ14
      npc_ff <= pc_fix(next_instr_addr);
      npsw_ff <= psw_ff;
    end else if (ld_ok && sr_wr.num == `SR_NMI_PC) begin
      npc_ff <= sr_wr.data & PCK; // see RQ15
    end else if (ld_ok && sr_wr.num == `SR_NMI_PSW) begin
      npsw_ff <= psw_fix(sr_wr.data);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tpc_ff <= `ZERO_WORD;
      tpsw_ff <= `ZERO_WORD;
    end else if (event_kind == EV_TABLE_CALL) begin // see RQ21
      tpc_ff <= pc_fix(next_instr_addr);
      tpsw_ff <= psw_ff;
    end else if (ld_ok && sr_wr.num == `SR_TBL_PC) begin
      tpc_ff <= sr_wr.data & PCK;
    end else if (ld_ok && sr_wr.num == `SR_TBL_PSW) begin
      tpsw_ff <= psw_fix(sr_wr.data);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dpc_ff <= `ZERO_WORD;
      dpsw_ff <= `ZERO_WORD;
    end else if (event_kind == EV_DEBUG_TRAP) begin
      dpc_ff <= pc_fix(next_instr_addr);
      dpsw_ff <= psw_ff;
    end else if (ld_ok && dbg_ok && sr_wr.num == `SR_DBG_PC) begin // see RQ9
      dpc_ff <= sr_wr.data & PCK;
    end else if (ld_ok && dbg_ok && sr_wr.num == `SR_DBG_PSW) begin
      dpsw_ff <= psw_fix(sr_wr.data);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) tbase_ff <= `ZERO_WORD;
    else if (ld_ok && sr_wr.num == `SR_TBL_BASE) tbase_ff <= sr_wr.data;
  end

  // load to the code number falls through: no write path
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ecode_ff <= `ZERO_WORD;
    end else if (event_kind == EV_MASKABLE || event_kind == EV_NMI ||
                 event_kind == EV_DEBUG_TRAP) begin // see RQ18 // see RQ8
      ecode_ff <= event_code;
    end
  end

  // ----------------------------------------
  // store path
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ff <= `ZERO_WORD;
    end else begin
      case (sr_rd_num)
        `SR_MASK_PC: rd_ff <= mpc_ff;
        `SR_MASK_PSW: rd_ff <= mpsw_ff;
        `SR_NMI_PC: rd_ff <= npc_ff;
        `SR_NMI_PSW: rd_ff <= npsw_ff;
        `SR_EXC_CODE: rd_ff <= ecode_ff;
        `SR_PSW: rd_ff <= psw_ff;
        `SR_TBL_PC: rd_ff <= tpc_ff;
        `SR_TBL_PSW: rd_ff <= tpsw_ff;
        `SR_DBG_PC: rd_ff <= dbg_ok ? dpc_ff : `ZERO_WORD; // see RQ9
        `SR_DBG_PSW: rd_ff <= dbg_ok ? dpsw_ff : `ZERO_WORD;
        `SR_TBL_BASE: rd_ff <= tbase_ff;
        default: rd_ff <= `ZERO_WORD; // see RQ7 // see RQ2
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic dbgw_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) dbgw_ff <= 1'b0;
    else dbgw_ff <= (nxt_dbg == DBG_OPEN);
  end

  assign sr_rd_data = rd_ff;
  assign pc = pc_ff;
  assign processor_status_word = psw_ff;
  assign ack_hold = hold_ff;
  assign debug_window = dbgw_ff;

endmodule : cpu_regs

`default_nettype wire

/* cpu_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defs.svh"
module cpu_regs_chk
  import cpu_regs_pkg::*;
#(
  parameter int PC_WIDTH = 26
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // requests
  input wire cpu_regs_pkg::gpr_wr_t gpr_wr,
  input wire logic [4:0] gpr_rd_a_addr,
  input wire logic [4:0] gpr_rd_b_addr,
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire cpu_regs_pkg::cpu_event_t event_kind,
  input wire logic [31:0] event_new_pc,
  input wire logic [7:0] event_new_psw,
  input wire cpu_regs_pkg::sr_wr_t sr_wr,
  input wire logic [4:0] sr_rd_num,
  // answers
  input wire logic [31:0] gpr_rd_a_data,
  input wire logic [31:0] gpr_rd_b_data,
  input wire logic [31:0] sr_rd_data,
  input wire logic [31:0] pc,
  input wire logic [31:0] processor_status_word,
  input wire logic ack_hold,
  input wire logic debug_window
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_PC_FIXED: assert property (pc[31:PC_WIDTH] == '0 && !pc[0])
    else $error("pc reserved bits set");
  AST_ST_RSVD: assert property (processor_status_word[31:8] == 24'h000000)
    else $error("status word upper bits set");
  AST_PC_LOAD: assert property (pc_load && event_kind == EV_NONE
    |=> pc == ($past(pc_next) & `PC_MASK)) else $error("pc load wrong");
  AST_ST_LOAD: assert property (sr_wr.ld && sr_wr.num == 5'h05 && event_kind == EV_NONE
    |=> ack_hold && processor_status_word == (32'h000000FF & $past(sr_wr.data))) else $error("status load wrong");
  AST_ACK_DROP: assert property (ack_hold && !(sr_wr.ld && sr_wr.num == 5'h05)
    |=> !ack_hold) else $error("ack hold stuck");
  AST_EVENT_LOAD: assert property (event_kind inside {EV_MASKABLE, EV_NMI, EV_DEBUG_TRAP}
    |=> pc == ($past(event_new_pc) & `PC_MASK) && processor_status_word[7:0] == $past(event_new_psw))
    else $error("event entry wrong");
  AST_ZERO_READ: assert property (gpr_rd_b_addr == 5'h00 |=> gpr_rd_b_data == 32'h00000000)
    else $error("zero register nonzero");
  AST_FORWARD: assert property (gpr_wr.en && gpr_wr.addr == gpr_rd_a_addr
    |=> gpr_rd_a_data == (($past(gpr_wr.addr) == 5'h00) ? 32'h00000000 : $past(gpr_wr.data)))
    else $error("forwarded read wrong");
  AST_RSVD_READ: assert property (sr_rd_num inside {[5'h06:5'h0F], [5'h15:5'h1F]}
    |=> sr_rd_data == 32'h00000000) else $error("reserved number reads nonzero");
  AST_DBG_GATE: assert property (sr_rd_num inside {5'h12, 5'h13} && !debug_window
    |=> sr_rd_data == 32'h00000000) else $error("debug save visible while closed");
  AST_DBG_OPEN: assert property (event_kind == EV_DEBUG_TRAP |=> debug_window)
    else $error("debug window not opened");
endmodule : cpu_regs_chk
bind cpu_regs cpu_regs_chk #(.PC_WIDTH(PC_WIDTH)) chk (.*);
`default_nettype wire

/* cpu_exec_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_exec_model
  import cpu_regs_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // commands to the register set
  output var logic pc_load,
  output var logic [31:0] pc_next,
  output var logic [31:0] next_instr_addr,
  output var cpu_regs_pkg::cpu_event_t event_kind,
  output var logic [31:0] event_code,
  output var logic [31:0] event_new_pc,
  output var logic [7:0] event_new_psw,
  output var logic [7:0] flags_upd,
  output var logic flags_upd_en,
  output var cpu_regs_pkg::sr_wr_t sr_wr
);
  // released load data and event pc toggle so a stale value never passes for a fresh one
  task automatic idle;
    pc_load = 1'b0;
    flags_upd_en = 1'b0;
    sr_wr.ld = 1'b0;
    event_kind = EV_NONE;
    sr_wr.data = ~sr_wr.data;
    event_new_pc = ~event_new_pc;
  endtask : idle
  task automatic step;
    @(posedge ref_clk);
    #1 idle();
  endtask : step
  initial begin
    {pc_next, next_instr_addr, event_code, event_new_pc, event_new_psw, flags_upd, sr_wr} = '0;
    idle();
  end
  task automatic ld(input logic [4:0] n, input logic [31:0] d);
    @(posedge ref_clk);
    #1 sr_wr = '{num: n, data: d, ld: 1'b1};
    step();
  endtask : ld
  task automatic ev(input cpu_event_t k, input logic [31:0] nia, input logic [31:0] code,
                    input logic [31:0] npc, input logic [7:0] nst);
    @(posedge ref_clk);
    #1 event_kind = k;
    {next_instr_addr, event_code} = {nia, code};
    {event_new_pc, event_new_psw} = {npc, nst};
    step();
  endtask : ev
  task automatic pcl(input logic [31:0] v);
    @(posedge ref_clk);
    #1 {pc_load, pc_next} = {1'b1, v};
    step();
  endtask : pcl
  task automatic fl(input logic [7:0] v);
    @(posedge ref_clk);
    #1 {flags_upd_en, flags_upd} = {1'b1, v};
    step();
  endtask : fl
endmodule : cpu_exec_model
`default_nettype wire

/* cpu_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defs.svh"
module cpu_regs_test;
  import cpu_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  gpr_wr_t gpr_wr = '0;
  logic [4:0] gpr_rd_a_addr = 5'h00;
  logic [4:0] gpr_rd_b_addr = 5'h00;
  logic [4:0] sr_rd_num = 5'h00;
  logic [31:0] gpr_rd_a_data, gpr_rd_b_data, sr_rd_data, pc, processor_status_word;
  logic [31:0] pc_next, next_instr_addr, event_code, event_new_pc;
  logic [7:0] event_new_psw, flags_upd;
  logic pc_load, flags_upd_en, ack_hold, debug_window, dbgm;
  cpu_event_t event_kind;
  sr_wr_t sr_wr;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] srm [32];
  logic [31:0] gm [32];
  logic [31:0] pcm;
  always #20 ref_clk = ~ref_clk;
  cpu_exec_model px (.*);
  cpu_regs DUT (.*);
  // ----------------
  // expectations
  // ----------------
  function automatic logic [31:0] ld_mask(input int n);
    case (n)
      0, 2, 16: return 32'h03FFFFFF;
      1, 3, 5, 17: return 32'h000000FF;
      18: return dbgm ? 32'h03FFFFFF : 32'h00000000;
      19: return dbgm ? 32'h000000FF : 32'h00000000;
      20: return 32'hFFFFFFFF;
      default: return 32'h00000000;
    endcase
  endfunction : ld_mask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rd_all;
    for (int n = 0; n < 32; n++) begin
      @(posedge ref_clk);
      #1 sr_rd_num = 5'(n);
      @(posedge ref_clk);
      #1 chk(sr_rd_data, (n inside {18, 19} && !dbgm) ? 32'h00000000 : srm[n], "sysreg");
    end
    chk(pc, pcm, "pc");
    chk(processor_status_word, srm[5], "status word");
  endtask : rd_all
  task automatic do_ld(input int n, input logic [31:0] d);
    logic [31:0] m;
    m = ld_mask(n);
    px.ld(5'(n), d);
    if (m != 32'h00000000) srm[n] = d & m;
    if (n == 5) chk({31'h00000000, ack_hold}, 32'h00000001, "ack hold");
  endtask : do_ld
  task automatic save(input int b, input logic [31:0] nia, input logic [31:0] code, input bit rec);
    srm[b] = nia & `PC_MASK;
    srm[b + 1] = srm[5];
    if (rec) srm[4] = code;
  endtask : save
  task automatic do_ev(input cpu_event_t k);
    logic [31:0] nia, code, npc;
    logic [7:0] nst;
    {nia, code, npc, nst} = {$urandom, $urandom, $urandom, 8'($urandom)};
    px.ev(k, nia, code, npc, nst);
    case (k)
      EV_MASKABLE: save(0, nia, code, 1'b1);
      EV_NMI: save(2, nia, code, 1'b1);
      EV_TABLE_CALL: save(16, nia, code, 1'b0);
      EV_DEBUG_TRAP: save(18, nia, code, 1'b1);
      default: ;
    endcase
    if (k inside {EV_MASKABLE, EV_NMI, EV_TABLE_CALL, EV_DEBUG_TRAP}) begin
      {pcm, srm[5]} = {npc & `PC_MASK, 24'h000000, nst};
    end else begin
      npc = (k == EV_DEBUG_RETURN) ? 18 : (srm[5][7] ? 2 : 0);
      {pcm, srm[5]} = {srm[npc] & `PC_MASK, srm[npc + 1] & 32'h000000FF};
    end
    dbgm = (k == EV_DEBUG_TRAP) ? 1'b1 : ((k == EV_DEBUG_RETURN) ? 1'b0 : dbgm);
    chk(pc, pcm, "pc after event");
    chk(processor_status_word, srm[5], "status after event");
    chk({31'h00000000, debug_window}, {31'h00000000, dbgm}, "debug window");
  endtask : do_ev
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'hA512));
    srm = '{default: 32'h00000000};
    gm = '{default: 32'h00000000};
    {pcm, dbgm, srm[5]} = {32'h00000000, 1'b0, 32'h00000020};
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    rd_all();
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1 gpr_wr = '{addr: (i < 2) ? 5'h00 : 5'($urandom), data: $urandom, en: 1'b1};
      gpr_rd_a_addr = gpr_wr.addr;
      gpr_rd_b_addr = 5'($urandom);
      if (gpr_wr.addr != 5'h00) gm[gpr_wr.addr] = gpr_wr.data;
      @(posedge ref_clk);
      #1 gpr_wr.en = 1'b0;
      chk(gpr_rd_a_data, gm[gpr_rd_a_addr], "gpr a");
      chk(gpr_rd_b_data, gm[gpr_rd_b_addr], "gpr b");
    end
    for (int n = 0; n < 32; n++) do_ld(n, $urandom | 32'h00000001);
    rd_all();
    px.pcl(32'hFFFFFFFF);
    pcm = 32'h03FFFFFE;
    chk(pc, pcm, "pc load");
    px.fl(8'hA5);
    srm[5] = 32'h000000A5;
    chk(processor_status_word, srm[5], "flags");
    for (int i = 0; i < 40; i++) begin
      do_ev((i < 6) ? cpu_event_t'(i + 1) : cpu_event_t'($urandom_range(6, 1)));
      do_ld(dbgm ? 18 + i % 2 : $urandom_range(31, 0), $urandom | 32'h00000001);
      if (i % 6 == 3) rd_all();
    end
    rd_all();
    final_report();
  end
endmodule : cpu_regs_test
`default_nettype wire
